// ==== rtl/fpms_pkg.sv ====
// Package for the floating-point multiply sequencer
// Assumes an APB master with 32-bit data and one pclk domain
package fpms_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] FPMS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] FPMS_STATUS_OFS = 8'h04;
    localparam logic [7:0] FPMS_LATCH_OFS  = 8'h08;
    localparam logic [7:0] FPMS_BREG_OFS   = 8'h0c;
    localparam logic [7:0] FPMS_AREG_OFS   = 8'h10;
    localparam logic [7:0] FPMS_EXP_OFS    = 8'h14;
    localparam logic [7:0] FPMS_SIGNS_OFS  = 8'h18;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FPMS_CTRL_START_BIT = 0;
    localparam int FPMS_CTRL_OOR_BIT   = 1;
    localparam int FPMS_SIGN_A_BIT     = 0;
    localparam int FPMS_SIGN_B_BIT     = 1;
    // ------------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] FPMS_SC_LOAD   = 5'h0b;
    localparam logic [4:0] FPMS_SC_LAST   = 5'h01;
    localparam logic [7:0] FPMS_EXP_MAX   = 8'hff;
    localparam logic [7:0] FPMS_EXP_RST   = 8'h00;
    localparam logic [1:0] FPMS_OP_NONE   = 2'h0;
    localparam logic [1:0] FPMS_OP_ADD1   = 2'h1;
    localparam logic [1:0] FPMS_OP_ADD2   = 2'h2;
    localparam logic [1:0] FPMS_OP_SUB1   = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_SETUP    = 4'h1,
        ST_LOOP     = 4'h3,
        ST_FADD     = 4'h2,
        ST_COPY     = 4'h6,
        ST_NORM     = 4'h7,
        ST_ZERO     = 4'h5,
        ST_CONDITIONAL_UNDERFLOW     = 4'h4,
        ST_UFL      = 4'hc,
        ST_ALTCOPY  = 4'hd,
        ST_OFL_A    = 4'hf,
        ST_RESTORE  = 4'he,
        ST_ZERO_ALT = 4'ha,
        ST_RSEL     = 4'hb,
        ST_OFL_B    = 4'h9
    } fpms_state_t;

    // Result of one multiplier pair evaluation
    typedef struct packed {
        logic [1:0] op;
        logic       carry;
    } fpms_eval_t;
endpackage

// ==== rtl/fpms_seq.sv ====
// Floating-point multiply sequencer: radix-4 loop, exponent checks, endings
// Assumes an APB master on pclk; operands are loaded over APB while idle
// Function
// - First pair is zero high bit and latch bit 00.
// - Setup loads pair buffer from latch bits 01,02; latch goes to multiplier.
// - Each loop period reloads pair buffer from multiplier bits 28,29.
// - Multiplier shifts right two each loop period except the first.
// - Setup loads counter with 11; loop counts down; exit at 1.
// - Loop step holds until count reaches 1, lasting eleven periods.
// - Active flag set on loop entry enables evaluate, pair reload and multiplier shift.
// - Loop leaves exponent unchanged; code 255 sets exponent carry.
// - Final add completes product and sets zero flag if zero.
// - In range, carry jumps to conditional underflow, else copy.
// - Copy A to B; sign overflow or zero jumps to normalize.
// - Normalize shifts A,B right one, bumps exponent; zero goes zeroing.
// - Zeroing clears fractions, exponent and result sign; ends.
// - Out of range, carry means conditional overflow; go alternate copy.
// - Alternate copy A to B; normalized ends, shift needed overflows.
// - Overflow format sets A, B, exponent all ones; sign kept.
// - No conditional overflow: restore exponent plus one; zero goes zeroing.
// - Nonzero out of range: exponent msb one underflows, else overflows.
// - Underflow format zeroes every field including sign; ends.
// - Conditional underflow: sign or zero normalizes, else underflow.
// - Setup makes result sign low if signs equal, high otherwise.
// - Three times M is subtract M plus carry; 2M is B shifted left.
// - Twelve pairs take thirteen periods by overlapping add and evaluate.
`timescale 1ns/1ps
module fpms_seq
    import fpms_pkg::*;
#(
    parameter int FW = 24,
    parameter int DW = 32
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mult_done
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fpms_state_t       state_ff;
    fpms_state_t       nxt_state;
    fpms_eval_t        pend_ff;
    logic [FW+1:0]     acc_ff;
    logic [FW-1:0]     b_ff;
    logic [7:0]        e_ff;
    logic [DW-1:0]     dl_ff;
    logic [DW-1:0]     mq_ff;
    logic [1:0]        pb_ff;
    logic [4:0]        sc_ff;
    logic              mu_ff;
    logic              exponent_carry_flag_ff;
    logic              zero_ff;
    logic              as_ff;
    logic              sa_ff;
    logic              sb_ff;
    logic              oor_ff;
    logic              done_ff;
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;

    logic              wr_en;
    logic              rd_en;
    logic              idle;
    logic              start;
    logic [FW+1:0]     sum;
    logic [FW-1:0]     a_view;
    logic              a_sgn;
    logic              a_nrm;
    logic              first_loop;
    logic [DW-1:0]     mq_shr;

    assign idle       = (state_ff == ST_IDLE);
    assign wr_en      = psel && penable && pready_ff && pwrite;
    assign rd_en      = psel && penable && !pready_ff && !pwrite;
    assign start      = wr_en && idle && (paddr == FPMS_CTRL_OFS)
                        && pwdata[FPMS_CTRL_START_BIT];
    assign a_view     = acc_ff[FW-1:0];
    assign a_sgn      = a_view[FW-1];
    assign a_nrm      = !a_sgn && a_view[FW-2];
    assign first_loop = (sc_ff == FPMS_SC_LOAD);
    assign mq_shr     = mq_ff >> 2;

    // ------------------------------------------------------------------
    // Pair evaluation
    // ------------------------------------------------------------------
    function automatic fpms_eval_t eval_pair(input logic [1:0] pr, input logic ci);
        fpms_eval_t r;
        logic [2:0] v;
        v = {1'b0, pr} + {2'b00, ci};
        r = '{op: FPMS_OP_NONE, carry: 1'b0};
        unique case (v)
            3'h1: r.op = FPMS_OP_ADD1;
            3'h2: r.op = FPMS_OP_ADD2;
            3'h3: r = '{op: FPMS_OP_SUB1, carry: 1'b1};
            3'h4: r.carry = 1'b1;
            default: r.op = FPMS_OP_NONE;
        endcase
        return r;
    endfunction

    // Component add; 2M is B shifted left
    always_comb
    begin
        unique case (pend_ff.op)
            FPMS_OP_ADD1: sum = acc_ff + {2'b00, b_ff};
            FPMS_OP_ADD2: sum = acc_ff + {1'b0, b_ff, 1'b0};
            FPMS_OP_SUB1: sum = acc_ff - {2'b00, b_ff};
            default:      sum = acc_ff;
        endcase
    end

    // ------------------------------------------------------------------
    // Step sequence
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:     if (start) nxt_state = ST_SETUP;
            ST_SETUP:    nxt_state = ST_LOOP;
            ST_LOOP:     if (sc_ff == FPMS_SC_LAST) nxt_state = ST_FADD;
            ST_FADD:
                if (oor_ff)
                    nxt_state = exponent_carry_flag_ff ? ST_ALTCOPY : ST_RESTORE;
                else
                    nxt_state = exponent_carry_flag_ff ? ST_CONDITIONAL_UNDERFLOW : ST_COPY;
            ST_COPY:     nxt_state = (a_sgn || zero_ff) ? ST_NORM : ST_IDLE;
            ST_NORM:     nxt_state = zero_ff ? ST_ZERO : ST_IDLE;
            ST_CONDITIONAL_UNDERFLOW:     nxt_state = (a_sgn || zero_ff) ? ST_NORM : ST_UFL;
            ST_ALTCOPY:  nxt_state = (a_sgn || zero_ff) ? ST_OFL_A : ST_IDLE;
            ST_RESTORE:  nxt_state = zero_ff ? ST_ZERO_ALT : ST_RSEL;
            ST_RSEL:     nxt_state = e_ff[7] ? ST_UFL : ST_OFL_B;
            ST_ZERO, ST_ZERO_ALT, ST_UFL, ST_OFL_A, ST_OFL_B:
                nxt_state = ST_IDLE;
            default:     nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Done pulse in the cycle after the terminating step
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_ff <= 1'b0;
        else
            done_ff <= !idle && (nxt_state == ST_IDLE);
    end

    // ------------------------------------------------------------------
    // Shift counter and active flag
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sc_ff <= 5'h00;
        else if (state_ff == ST_SETUP)
            sc_ff <= FPMS_SC_LOAD;
        else if (state_ff == ST_LOOP)
            sc_ff <= sc_ff - 5'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mu_ff <= 1'b0;
        else if (state_ff == ST_SETUP)
            mu_ff <= 1'b1;
        else if (state_ff == ST_FADD)
            mu_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Multiplier register, pair buffer, pending component
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mq_ff   <= '0;
            pb_ff   <= 2'h0;
            pend_ff <= '0;
        end
        else if (state_ff == ST_SETUP)
        begin
            mq_ff   <= dl_ff;
            pb_ff   <= dl_ff[2:1];
            pend_ff <= eval_pair({1'b0, dl_ff[0]}, 1'b0);
        end
        else if (state_ff == ST_LOOP && mu_ff)
        begin
            // Add of previous pair overlaps evaluation of this one
            pend_ff <= eval_pair(pb_ff, pend_ff.carry);
            if (!first_loop)
                mq_ff <= mq_shr;
            pb_ff <= first_loop ? mq_ff[29:28] : mq_shr[29:28];
        end
    end

    // ------------------------------------------------------------------
    // Fraction, exponent and sign datapath
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_ff  <= '0;
            b_ff    <= '0;
            e_ff    <= FPMS_EXP_RST;
            as_ff   <= 1'b0;
            exponent_carry_flag_ff <= 1'b0;
            zero_ff <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (wr_en)
                    begin
                        if (paddr == FPMS_BREG_OFS)
                            b_ff <= pwdata[FW-1:0];
                        if (paddr == FPMS_EXP_OFS)
                            e_ff <= pwdata[7:0];
                    end
                ST_SETUP:
                begin
                    acc_ff  <= '0;
                    exponent_carry_flag_ff <= 1'b0;
                    as_ff   <= sa_ff ^ sb_ff;
                end
                ST_LOOP:
                begin
                    acc_ff <= $signed(sum) >>> 2;
                    if (e_ff == FPMS_EXP_MAX)
                        exponent_carry_flag_ff <= 1'b1;
                end
                ST_FADD:
                begin
                    acc_ff  <= sum;
                    zero_ff <= (sum[FW-1:0] == '0);
                end
                ST_COPY, ST_ALTCOPY:
                    b_ff <= a_view;
                ST_NORM:
                begin
                    acc_ff <= {3'b000, a_view[FW-1:1]};
                    b_ff   <= a_view >> 1;
                    e_ff   <= e_ff + 8'h01;
                end
                ST_RESTORE:
                    e_ff <= e_ff + 8'h01;
                ST_ZERO, ST_ZERO_ALT, ST_UFL:
                begin
                    acc_ff <= '0;
                    b_ff   <= '0;
                    e_ff   <= 8'h00;
                    as_ff  <= 1'b0;
                end
                ST_OFL_A, ST_OFL_B:
                begin
                    acc_ff <= {2'b00, {FW{1'b1}}};
                    b_ff   <= '1;
                    e_ff   <= FPMS_EXP_MAX;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dl_ff  <= '0;
            sa_ff  <= 1'b0;
            sb_ff  <= 1'b0;
            oor_ff <= 1'b0;
        end
        else if (wr_en && idle)
        begin
            if (paddr == FPMS_LATCH_OFS)
                dl_ff <= pwdata[DW-1:0];
            if (paddr == FPMS_SIGNS_OFS)
            begin
                sa_ff <= pwdata[FPMS_SIGN_A_BIT];
                sb_ff <= pwdata[FPMS_SIGN_B_BIT];
            end
            if (paddr == FPMS_CTRL_OFS)
                oor_ff <= pwdata[FPMS_CTRL_OOR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, error on unmapped address
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end
        else
        begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
            if (psel && penable && !pready_ff)
            begin
                unique case (paddr)
                    FPMS_CTRL_OFS:   prdata_ff <= {30'h0, oor_ff, 1'b0};
                    FPMS_STATUS_OFS:
                        prdata_ff <= {22'h0, state_ff, as_ff, zero_ff, exponent_carry_flag_ff,
                                      mu_ff, done_ff, !idle};
                    FPMS_SIGNS_OFS:  prdata_ff <= {30'h0, sb_ff, sa_ff};
                    FPMS_LATCH_OFS, FPMS_BREG_OFS, FPMS_AREG_OFS, FPMS_EXP_OFS:
                        ;
                    default:         pslverr_ff <= 1'b1;
                endcase
                if (rd_en)
                begin
                    if (paddr == FPMS_LATCH_OFS)
                        prdata_ff <= 32'(dl_ff);
                    if (paddr == FPMS_BREG_OFS)
                        prdata_ff <= 32'(b_ff);
                    if (paddr == FPMS_AREG_OFS)
                        prdata_ff <= 32'(a_view);
                    if (paddr == FPMS_EXP_OFS)
                        prdata_ff <= {24'h0, e_ff};
                end
            end
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign mult_done = done_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    setup_count_a: assert property (state_ff == ST_SETUP |=> sc_ff == 5'h0b)
        else $error("shift counter not loaded with 11");
    loop_length_a: assert property (state_ff == ST_SETUP |-> ##12 state_ff == ST_FADD)
        else $error("loop did not last eleven periods");
    pair_load_a: assert property (state_ff == ST_SETUP |=> pb_ff == $past(dl_ff[2:1]))
        else $error("pair buffer not loaded from latch");
    mq_shift_a: assert property (state_ff == ST_LOOP && !first_loop
                                 |=> mq_ff == ($past(mq_ff) >> 2))
        else $error("multiplier not shifted by two");
    active_flag_a: assert property (state_ff == ST_LOOP |-> mu_ff)
        else $error("active flag low during loop");
    sign_set_a: assert property (state_ff == ST_SETUP |=> as_ff == $past(sa_ff ^ sb_ff))
        else $error("result sign wrong");
    exp_carry_a: assert property (state_ff == ST_LOOP && e_ff == 8'hff |=> exponent_carry_flag_ff)
        else $error("exponent carry not set");
    conditional_underflow_jump_a: assert property (state_ff == ST_FADD && !oor_ff && exponent_carry_flag_ff
                                  |=> state_ff == ST_CONDITIONAL_UNDERFLOW)
        else $error("no jump to conditional underflow");
    zero_format_a: assert property (state_ff == ST_ZERO
                                    |=> a_view == '0 && e_ff == 8'h00 && !as_ff && done_ff)
        else $error("zero format incomplete");
    ovf_format_a: assert property ($rose(state_ff == ST_OFL_B)
                                   |=> e_ff == 8'hff && b_ff == '1 && $stable(as_ff))
        else $error("overflow format wrong");
    ufl_format_a: assert property (state_ff == ST_UFL |=> e_ff == 8'h00 && !as_ff ##1 !mult_done)
        else $error("underflow format wrong");

    normal_end_c: cover property (state_ff == ST_COPY ##1 state_ff == ST_IDLE);
    norm_end_c:   cover property (state_ff == ST_NORM ##1 state_ff == ST_IDLE);
    ufl_path_c:   cover property (state_ff == ST_CONDITIONAL_UNDERFLOW ##1 state_ff == ST_UFL);
    ovf_path_c:   cover property (state_ff == ST_RSEL ##1 state_ff == ST_OFL_B);
endmodule // fpms_seq

// ==== bench/fpms_operand_src.sv ====
// Operand source standing in for the control store and the data latch feed
// Assumes the bench selects one operand set at a time by index 0 to 5
`timescale 1ns/1ps
module fpms_operand_src
    import fpms_pkg::*;
(
    input  wire logic [2:0]  sel,
    output logic      [31:0] latch_word,
    output logic      [23:0] mcand,
    output logic      [7:0]  exp_code,
    output logic      [1:0]  signs,
    output logic             oor
);
    // ------------------------------------------------------------------
    // Operand table
    // ------------------------------------------------------------------
    localparam logic [7:0] EXP_TAB [0:5] = '{8'h40, 8'h10, 8'h80, 8'h10, 8'hff, 8'hff};
    localparam logic [5:0] OOR_TAB       = 6'b101110;

    // Sets 2 and 3 carry a nonzero multiplier
    assign latch_word = (sel == 3'h2 || sel == 3'h3) ? 32'h3fffffff : 32'h00000000;
    assign mcand      = 24'h400000;
    assign exp_code   = EXP_TAB[sel];
    assign signs      = (sel == 3'h5) ? 2'h2 : 2'h1;
    assign oor        = OOR_TAB[sel];
endmodule // fpms_operand_src

// ==== bench/fpms_seq_tb_top.sv ====
// Self-checking bench for the multiply sequencer, driven over APB
// Assumes the operand source model feeds each multiply's operand set
`timescale 1ns/1ps
module fpms_seq_tb_top
    import fpms_pkg::*;
();
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mult_done;
    logic [2:0]  sel       = 3'h0;
    logic [31:0] latch_word;
    logic [23:0] mcand;
    logic [7:0]  exp_code;
    logic [1:0]  signs;
    logic        oor;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc_cnt    = 0;
    int          done_at    = 0;

    fpms_seq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mult_done(mult_done));

    fpms_operand_src i_src (.sel(sel), .latch_word(latch_word), .mcand(mcand),
        .exp_code(exp_code), .signs(signs), .oor(oor));

    always #5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Cycle stamp of the completion pulse
    // ------------------------------------------------------------------
    always @(posedge pclk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (mult_done === 1'b1)
            done_at <= cyc_cnt;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int guard;
        guard = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && guard < 20)
        begin
            @(posedge pclk);
            guard++;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (guard >= 20)
            chk("pready", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_regs();
        logic [31:0] r;
        logic        e;
        apb(1'b0, FPMS_STATUS_OFS, 32'h0, r, e);
        chk("status_rst", 32'h0, r);
        apb(1'b0, FPMS_EXP_OFS, 32'h0, r, e);
        chk("exp_rst", {24'h0, FPMS_EXP_RST}, r);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        $display("test reset_regs done");
    endtask

    // One multiply: load operands, start, time completion, read result
    task automatic run_mult(input logic [2:0] s, input int cyc, input logic [23:0] eb,
                            input logic [7:0] ee, input logic es, input logic poke);
        logic [31:0] r;
        logic        e;
        int          c0;
        int          guard;
        sel = s;
        #1;
        wr(FPMS_SIGNS_OFS, {30'h0, signs});
        wr(FPMS_BREG_OFS, {8'h0, mcand});
        wr(FPMS_LATCH_OFS, latch_word);
        wr(FPMS_EXP_OFS, {24'h0, exp_code});
        done_at = 0;
        wr(FPMS_CTRL_OFS, {30'h0, oor, 1'b1});
        c0 = cyc_cnt;
        guard = 0;
        if (poke)
        begin
            apb(1'b0, FPMS_STATUS_OFS, 32'h0, r, e);
            chk("busy", 32'h1, {31'h0, r[0]});
            wr(FPMS_SIGNS_OFS, 32'h0);
        end
        while (done_at == 0 && guard < 60)
        begin
            @(posedge pclk);
            guard++;
        end
        chk("done_cycles", cyc, done_at - c0);
        apb(1'b0, FPMS_BREG_OFS, 32'h0, r, e);
        chk("breg", {8'h0, eb}, {8'h0, r[23:0]});
        apb(1'b0, FPMS_AREG_OFS, 32'h0, r, e);
        chk("areg", {8'h0, eb}, {8'h0, r[23:0]});
        apb(1'b0, FPMS_EXP_OFS, 32'h0, r, e);
        chk("exp", {24'h0, ee}, {24'h0, r[7:0]});
        apb(1'b0, FPMS_STATUS_OFS, 32'h0, r, e);
        chk("sign", {31'h0, es}, {31'h0, r[5]});
        if (poke)
        begin
            apb(1'b0, FPMS_SIGNS_OFS, 32'h0, r, e);
            chk("signs_kept", 32'h1, {30'h0, r[1:0]});
        end
        $display("test multiply %0d done", s);
    endtask

    task automatic t_inrange_zero();
        run_mult(3'h0, 17, 24'h000000, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_oor_zero();
        run_mult(3'h1, 16, 24'h000000, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_oor_underflow();
        run_mult(3'h2, 17, 24'h000000, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_oor_overflow_busy();
        run_mult(3'h3, 17, 24'hffffff, 8'hff, 1'b1, 1'b1);
    endtask

    task automatic t_cond_underflow();
        run_mult(3'h4, 17, 24'h000000, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_cond_overflow();
        run_mult(3'h5, 16, 24'hffffff, 8'hff, 1'b1, 1'b0);
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_regs();
        t_inrange_zero();
        t_oor_zero();
        t_oor_underflow();
        t_oor_overflow_busy();
        t_cond_underflow();
        t_cond_overflow();
        close_out();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        #300000;
        fail_count++;
        $display("mismatch watchdog expected finish seen hang");
        close_out();
    end
endmodule // fpms_seq_tb_top
